// >>> logic/status_report_map.vh
`ifndef STATUS_REPORT_MAP_VH
`define STATUS_REPORT_MAP_VH

// status word field positions
`define SW_MAIN_LSB      0
`define SW_MAIN_MSB      3
`define SW_SUB_LSB       4
`define SW_SUB_MSB       7
`define SW_INNER_LSB     8
`define SW_INNER_MSB     10
`define SW_MODE_LSB      11
`define SW_MODE_MSB      12
`define SW_CONF_LSB      13
`define SW_CONF_MSB      15
`define SW_CUR_LIM       16
`define SW_VOLT_LIM      17
`define SW_GRIDP_LIM     18
`define SW_CHG_LIM       20
`define SW_DIS_LIM       21
`define SW_BOOST_ON      23
`define SW_ISO_ON        24
`define SW_IN_CUR_LIM    25
`define SW_HEAT_LIM      27
`define SW_GRID_PRES     28
`define SW_AGG_MASTER    31
`define SW_RESET         32'h0000_0000

// main state codes
`define MS_INIT          4'h0
`define MS_STANDBY       4'h1
`define MS_POWER_ON      4'h2
`define MS_CHARGE        4'h3
`define MS_FAULT_HALT    4'h4
`define MS_STOPPING      4'h6
`define MS_WAIT_INNER    4'h7
`define MS_FAULT_ACK     4'h8

// sub-state codes
`define SS_INIT          4'h0
`define SS_POWER_OFF     4'h1
`define SS_PASSIVE_PRE   4'h2
`define SS_DRIVERS_ON    4'h3
`define SS_ACTIVE_PRE    4'h4
`define SS_CHARGING      4'h5
`define SS_STOPPING      4'h9
`define SS_FAULT_HALT    4'ha
`define SS_WAIT_INNER    4'hb
`define SS_FAULT_ACK     4'hc

// inner converter state codes
`define IS_INIT          3'h0
`define IS_STANDBY       3'h1
`define IS_READY         3'h2
`define IS_CHARGE        3'h3
`define IS_FAULT_HALT    3'h4
`define IS_STOPPING      3'h5
`define IS_WAIT_STANDBY  3'h6
`define IS_FAULT_ACK     3'h7

// mode and grid configuration codes
`define MODE_STANDBY     2'h0
`define MODE_GRID_POWER  2'h2
`define MODE_BATT_VOLT   2'h3
`define CONF_STANDBY     3'h0
`define CONF_DC_GRID     3'h5

// timing counts in 10 ns cycles: init 1 us, passive precharge 100 us,
// active precharge 20 us, inner stop 0.5 us; sized to the 16-bit timers
`define INIT_CYC         16'h0064
`define PASSIVE_PRE_CYC  16'h2710
`define ACTIVE_PRE_CYC   16'h07d0
`define INNER_STOP_CYC   16'h0032

`endif

// >>> logic/pin_sync.v
`timescale 1ns/10ps
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             sys_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_sync_q
);

reg [WIDTH-1:0] meta_q;

// first stage feeds only the second stage
always @(posedge sys_clk) begin
    if (sys_rst) begin
        meta_q     <= {WIDTH{1'b0}};
        pin_sync_q <= {WIDTH{1'b0}};
    end else begin
        meta_q     <= pin_in;
        pin_sync_q <= meta_q;
    end
end

endmodule // pin_sync

// >>> logic/converter_status_word_reporter.v
// Contract
// (R1) main state code in bits 0..3
// (R2) sub-state code in bits 4..7
// (R3) inner converter state in bits 8..10
// (R4) operating mode in bits 11..12
// (R5) grid configuration in bits 13..15
// (R6) current, voltage, grid power limits bits 16..18
// (R7) charge/discharge current limits bits 20, 21
// (R8) boost bit 23, isolated stage bit 24
// (R9) input current limit flag bit 25
// (R10) thermal limit flag bit 27
// (R11) grid present flag bit 28
// (R12) aggregating master flag bit 31
// (R13) main codes 0..4: init..fault halt
// (R14) main codes 6 stop, 7 wait, 8 ack
// (R15) fault halts main machine until user acts
// (R16) sub-states 0..5 follow start-up sequence
// (R17) sub-states 9, 10, 11, 12 as defined
// (R18) inner machine commanded by main machine
// (R19) reserved bits 19,22,26,29,30 read zero
// (R20) inner codes 0..7 as defined
// (R21) controller requests mode 0, 2 or 3
// (R22) controller requests configuration 5 or 0
// (R23) mode/config change only in standby
`timescale 1ns/10ps
`include "status_report_map.vh"
module converter_status_word_reporter #(
    parameter [15:0] INIT_CYC        = `INIT_CYC,
    parameter [15:0] PASSIVE_PRE_CYC = `PASSIVE_PRE_CYC,
    parameter [15:0] ACTIVE_PRE_CYC  = `ACTIVE_PRE_CYC,
    parameter [15:0] INNER_STOP_CYC  = `INNER_STOP_CYC
) (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire [1:0]  operating_mode_req,
    input  wire [2:0]  grid_config_req,
    input  wire        start_req,
    input  wire        stop_req,
    input  wire        standby_req,
    input  wire        critical_fault,
    input  wire        fault_ack_req,
    input  wire        max_current_limited,
    input  wire        max_voltage_limited,
    input  wire        grid_power_limited,
    input  wire        charge_current_limited,
    input  wire        discharge_current_limited,
    input  wire        input_current_limited,
    input  wire        heat_limited,
    input  wire        grid_present,
    input  wire        aggregating_master,
    output reg  [31:0] converter_state_report
);

////////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire [9:0] ctl_s;
wire [8:0] flg_s;

pin_sync #(
    .WIDTH (10)
) u_ctl_sync (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .pin_in     ({operating_mode_req, grid_config_req, start_req,
                  stop_req, standby_req, critical_fault, fault_ack_req}),
    .pin_sync_q (ctl_s)
);

pin_sync #(
    .WIDTH (9)
) u_flg_sync (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .pin_in     ({max_current_limited, max_voltage_limited,
                  grid_power_limited, charge_current_limited,
                  discharge_current_limited, input_current_limited,
                  heat_limited, grid_present, aggregating_master}),
    .pin_sync_q (flg_s)
);

wire [1:0] mode_s    = ctl_s[9:8];
wire [2:0] conf_s    = ctl_s[7:5];
wire       start_s   = ctl_s[4];
wire       stop_s    = ctl_s[3];
wire       standby_s = ctl_s[2];
wire       fault_s   = ctl_s[1];
wire       ack_s     = ctl_s[0];

////////////////////////////////////////////////////////////////////////////
// main supervisory machine

reg  [3:0]  main_state_code_q;
reg  [3:0]  main_state_code_d;
reg  [3:0]  main_substate_code_q;
reg  [3:0]  main_substate_code_d;
reg  [15:0] tmr_q;
reg  [15:0] tmr_d;
reg  [1:0]  operating_mode_code_q;
reg  [2:0]  grid_config_code_q;
reg  [2:0]  inner_converter_state_code_q;
reg  [2:0]  inner_converter_state_code_d;
reg  [15:0] inner_tmr_q;
reg  [15:0] inner_tmr_d;

// start requests accepted only when both codes name a usable setup
wire mode_ok  = (operating_mode_code_q == `MODE_GRID_POWER) ||
                (operating_mode_code_q == `MODE_BATT_VOLT);
wire conf_ok  = (grid_config_code_q == `CONF_DC_GRID);
wire can_halt = (main_state_code_q != `MS_INIT) &&
                (main_state_code_q != `MS_FAULT_HALT) &&
                (main_state_code_q != `MS_FAULT_ACK);
wire powered  = (main_state_code_q == `MS_POWER_ON) ||
                (main_state_code_q == `MS_CHARGE) ||
                ((main_state_code_q == `MS_STANDBY) &&
                 (main_substate_code_q != `SS_POWER_OFF));

// commands from the main machine to the inner machine
wire cmd_ready   = (main_substate_code_q == `SS_ACTIVE_PRE);
wire cmd_charge  = (main_state_code_q == `MS_POWER_ON);
wire cmd_stop    = (main_state_code_q == `MS_STOPPING);
wire cmd_standby = (main_state_code_q == `MS_WAIT_INNER) ||
                   (main_state_code_q == `MS_FAULT_ACK);

always @* begin
    main_state_code_d    = main_state_code_q;
    main_substate_code_d = main_substate_code_q;
    tmr_d                = tmr_q + 16'h0001;
    if (fault_s && can_halt) begin
        main_state_code_d    = `MS_FAULT_HALT; // R15
        main_substate_code_d = `SS_FAULT_HALT; // R17
    end else if (stop_s && powered) begin
        main_state_code_d    = `MS_STOPPING; // R14
        main_substate_code_d = `SS_STOPPING; // R17
    end else begin
        case (main_state_code_q)
            `MS_INIT: begin
                if (tmr_q >= INIT_CYC) begin
                    main_state_code_d    = `MS_STANDBY; // R13
                    main_substate_code_d = `SS_POWER_OFF; // R16
                end
            end
            `MS_STANDBY: begin
                case (main_substate_code_q)
                    `SS_POWER_OFF: begin
                        tmr_d = 16'h0000;
                        if (start_s && mode_ok && conf_ok) begin
                            main_substate_code_d = `SS_PASSIVE_PRE; // R16
                        end
                    end
                    `SS_PASSIVE_PRE: begin
                        if (tmr_q >= PASSIVE_PRE_CYC) begin
                            main_substate_code_d = `SS_DRIVERS_ON; // R16
                        end
                    end
                    `SS_DRIVERS_ON: begin
                        tmr_d                = 16'h0000;
                        main_substate_code_d = `SS_ACTIVE_PRE; // R16
                    end
                    `SS_ACTIVE_PRE: begin
                        if ((tmr_q >= ACTIVE_PRE_CYC) &&
                            (inner_converter_state_code_q == `IS_READY)) begin
                            main_state_code_d    = `MS_POWER_ON; // R13
                            main_substate_code_d = `SS_CHARGING; // R16
                        end
                    end
                    default: begin
                        main_substate_code_d = `SS_POWER_OFF;
                    end
                endcase
            end
            `MS_POWER_ON: begin
                if (inner_converter_state_code_q == `IS_CHARGE) begin
                    main_state_code_d = `MS_CHARGE; // R13
                end
            end
            `MS_CHARGE: begin
                main_substate_code_d = `SS_CHARGING;
            end
            `MS_FAULT_HALT: begin
                // leaves only on user action with the fault gone
                if (!fault_s && (ack_s || standby_s)) begin
                    main_state_code_d    = `MS_FAULT_ACK; // R15
                    main_substate_code_d = `SS_FAULT_ACK; // R17
                end
            end
            `MS_STOPPING: begin
                if ((inner_converter_state_code_q == `IS_WAIT_STANDBY) ||
                    (inner_converter_state_code_q == `IS_STANDBY)) begin
                    main_state_code_d    = `MS_WAIT_INNER; // R14
                    main_substate_code_d = `SS_WAIT_INNER; // R17
                end
            end
            `MS_WAIT_INNER, `MS_FAULT_ACK: begin
                if (inner_converter_state_code_q == `IS_STANDBY) begin
                    main_state_code_d    = `MS_STANDBY;
                    main_substate_code_d = `SS_POWER_OFF;
                end
            end
            default: begin
                main_state_code_d    = `MS_INIT;
                main_substate_code_d = `SS_INIT;
            end
        endcase
    end
end

always @(posedge sys_clk) begin
    if (sys_rst) begin
        main_state_code_q    <= `MS_INIT;
        main_substate_code_q <= `SS_INIT;
        tmr_q                <= 16'h0000;
    end else begin
        main_state_code_q    <= main_state_code_d;
        main_substate_code_q <= main_substate_code_d;
        tmr_q                <= tmr_d;
    end
end

// codes are sampled only in power-off standby, so a change while
// powered is ignored; the controller must hold them steady a few
// cycles since the bits cross from the pins independently
always @(posedge sys_clk) begin
    if (sys_rst) begin
        operating_mode_code_q <= `MODE_STANDBY;
        grid_config_code_q    <= `CONF_STANDBY;
    end else if ((main_state_code_q == `MS_STANDBY) &&
                 (main_substate_code_q == `SS_POWER_OFF)) begin
        operating_mode_code_q <= mode_s; // R23
        grid_config_code_q    <= conf_s; // R23
    end
end

////////////////////////////////////////////////////////////////////////////
// inner converter machine

always @* begin
    inner_converter_state_code_d = inner_converter_state_code_q;
    inner_tmr_d                  = 16'h0000;
    if (fault_s && (inner_converter_state_code_q != `IS_FAULT_HALT) &&
        (inner_converter_state_code_q != `IS_FAULT_ACK)) begin
        inner_converter_state_code_d = `IS_FAULT_HALT; // R20
    end else begin
        case (inner_converter_state_code_q)
            `IS_INIT: begin
                if (main_state_code_q != `MS_INIT) begin
                    inner_converter_state_code_d = `IS_STANDBY; // R18
                end
            end
            `IS_STANDBY: begin
                if (cmd_ready) begin
                    inner_converter_state_code_d = `IS_READY; // R18
                end
            end
            `IS_READY: begin
                if (cmd_stop) begin
                    inner_converter_state_code_d = `IS_STOPPING; // R18
                end else if (cmd_charge) begin
                    inner_converter_state_code_d = `IS_CHARGE; // R18
                end
            end
            `IS_CHARGE: begin
                if (cmd_stop) begin
                    inner_converter_state_code_d = `IS_STOPPING; // R18
                end
            end
            `IS_STOPPING: begin
                inner_tmr_d = inner_tmr_q + 16'h0001;
                if (inner_tmr_q >= INNER_STOP_CYC) begin
                    inner_converter_state_code_d = `IS_WAIT_STANDBY; // R20
                end
            end
            `IS_WAIT_STANDBY: begin
                if (cmd_standby) begin
                    inner_converter_state_code_d = `IS_STANDBY; // R18
                end
            end
            `IS_FAULT_HALT: begin
                if (main_state_code_q == `MS_FAULT_ACK) begin
                    inner_converter_state_code_d = `IS_FAULT_ACK; // R18
                end
            end
            `IS_FAULT_ACK: begin
                if (cmd_standby) begin
                    inner_converter_state_code_d = `IS_STANDBY; // R18
                end
            end
            default: begin
                inner_converter_state_code_d = `IS_INIT;
            end
        endcase
    end
end

always @(posedge sys_clk) begin
    if (sys_rst) begin
        inner_converter_state_code_q <= `IS_INIT;
        inner_tmr_q                  <= 16'h0000;
    end else begin
        inner_converter_state_code_q <= inner_converter_state_code_d;
        inner_tmr_q                  <= inner_tmr_d;
    end
end

////////////////////////////////////////////////////////////////////////////
// status word assembly

// boost runs from active pre-charge until the stop completes
wire boost_stage_running =
    (main_substate_code_q == `SS_ACTIVE_PRE) ||
    (main_substate_code_q == `SS_CHARGING) ||
    (main_substate_code_q == `SS_STOPPING);
wire isolated_stage_running =
    (inner_converter_state_code_q == `IS_CHARGE) ||
    (inner_converter_state_code_q == `IS_STOPPING);

reg [31:0] report_d;

always @* begin
    report_d = 32'h0000_0000; // R19
    report_d[`SW_MAIN_MSB:`SW_MAIN_LSB]   = main_state_code_q; // R1
    report_d[`SW_SUB_MSB:`SW_SUB_LSB]     = main_substate_code_q; // R2
    report_d[`SW_INNER_MSB:`SW_INNER_LSB] =
        inner_converter_state_code_q; // R3
    report_d[`SW_MODE_MSB:`SW_MODE_LSB]   = operating_mode_code_q; // R4
    report_d[`SW_CONF_MSB:`SW_CONF_LSB]   = grid_config_code_q; // R5
    report_d[`SW_CUR_LIM]    = flg_s[8]; // R6
    report_d[`SW_VOLT_LIM]   = flg_s[7]; // R6
    report_d[`SW_GRIDP_LIM]  = flg_s[6]; // R6
    report_d[`SW_CHG_LIM]    = flg_s[5]; // R7
    report_d[`SW_DIS_LIM]    = flg_s[4]; // R7
    report_d[`SW_BOOST_ON]   = boost_stage_running; // R8
    report_d[`SW_ISO_ON]     = isolated_stage_running; // R8
    report_d[`SW_IN_CUR_LIM] = flg_s[3]; // R9
    report_d[`SW_HEAT_LIM]   = flg_s[2]; // R10
    report_d[`SW_GRID_PRES]  = flg_s[1]; // R11
    report_d[`SW_AGG_MASTER] = flg_s[0]; // R12
end

always @(posedge sys_clk) begin
    if (sys_rst) begin
        converter_state_report <= `SW_RESET;
    end else begin
        converter_state_report <= report_d;
    end
end

endmodule // converter_status_word_reporter

// >>> tb/converter_status_word_reporter_monitor.sv
`timescale 1ns/10ps
module converter_status_word_reporter_monitor (
    input wire        sys_clk,
    input wire        sys_rst,
    input wire [1:0]  operating_mode_req,
    input wire [2:0]  grid_config_req,
    input wire        start_req,
    input wire        stop_req,
    input wire        standby_req,
    input wire        critical_fault,
    input wire        fault_ack_req,
    input wire        max_current_limited,
    input wire        max_voltage_limited,
    input wire        grid_power_limited,
    input wire        charge_current_limited,
    input wire        discharge_current_limited,
    input wire        input_current_limited,
    input wire        heat_limited,
    input wire        grid_present,
    input wire        aggregating_master,
    input wire [31:0] converter_state_report
);
    wire  [31:0] rep = converter_state_report;
    logic [2:0]  settle_q;
    // $past three deep is only trusted once the sync chain saw no reset
    always @(posedge sys_clk) begin
        if (sys_rst) settle_q <= 3'h0;
        else if (settle_q != 3'h4) settle_q <= settle_q + 3'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    property p_limit_bits;
        settle_q == 3'h4 |-> rep[18:16] == $past({grid_power_limited,
            max_voltage_limited, max_current_limited}, 3);
    endproperty
    a_limit_bits: assert property (p_limit_bits)
        else $error("limit flags misplaced");
    property p_batt_bits;
        settle_q == 3'h4 |-> rep[21:20] ==
            $past({discharge_current_limited, charge_current_limited}, 3);
    endproperty
    a_batt_bits: assert property (p_batt_bits)
        else $error("battery flags misplaced");
    property p_input_heat;
        settle_q == 3'h4 |->
            {rep[27], rep[25]} == $past({heat_limited, input_current_limited}, 3);
    endproperty
    a_input_heat: assert property (p_input_heat)
        else $error("input or heat flag misplaced");
    property p_grid_master;
        settle_q == 3'h4 |->
            {rep[31], rep[28]} == $past({aggregating_master, grid_present}, 3);
    endproperty
    a_grid_master: assert property (p_grid_master)
        else $error("grid or master flag misplaced");
    property p_reserved;
        {rep[30:29], rep[26], rep[22], rep[19]} == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");
    property p_main_legal;
        rep[3:0] <= 4'h8 && rep[3:0] != 4'h5;
    endproperty
    a_main_legal: assert property (p_main_legal)
        else $error("main state code illegal");
    property p_sub_legal;
        rep[7:4] <= 4'hc && !(rep[7:4] inside {4'h6, 4'h7, 4'h8});
    endproperty
    a_sub_legal: assert property (p_sub_legal)
        else $error("sub-state code illegal");
    property p_halt_hold;
        (rep[3:0] == 4'h4 && !fault_ack_req && !standby_req) [*4]
            |=> rep[3:0] == 4'h4;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("fault halt left without user action");
    property p_halt_pair;
        rep[3:0] == 4'h4 |-> rep[7:4] == 4'ha;
    endproperty
    a_halt_pair: assert property (p_halt_pair)
        else $error("fault halt without its sub-state");
    property p_mode_frozen;
        $changed(rep[15:11]) |-> $past(rep[3:0]) == 4'h1 || rep[3:0] == 4'h1;
    endproperty
    a_mode_frozen: assert property (p_mode_frozen)
        else $error("mode or config changed outside standby");
    c_charge: cover property (rep[3:0] == 4'h3);
    c_halt: cover property (rep[3:0] == 4'h4);
    c_stop: cover property (rep[3:0] == 4'h6 ##[1:40] rep[3:0] == 4'h7);
endmodule // converter_status_word_reporter_monitor

// >>> tb/supervisor_model.sv
`timescale 1ns/10ps
module supervisor_model (
    input  wire        sys_clk,
    output logic [1:0] operating_mode_req,
    output logic [2:0] grid_config_req,
    output logic       start_req,
    output logic       stop_req,
    output logic       standby_req,
    output logic       fault_ack_req
);
    initial begin
        operating_mode_req = 2'h0;
        grid_config_req = 3'h0;
        start_req = 1'b0;
        stop_req = 1'b0;
        standby_req = 1'b0;
        fault_ack_req = 1'b0;
    end
    // callers pass only modes 0, 2, 3 and configs 0, 5: others may harm
    task automatic set_mode(input logic [1:0] m, input logic [2:0] c);
        @(negedge sys_clk);
        operating_mode_req = m;
        grid_config_req = c;
    endtask
    task automatic run(input logic go, input logic halt);
        @(negedge sys_clk);
        start_req = go;
        stop_req = halt;
    endtask
    task automatic clear(input logic ack, input logic sby);
        @(negedge sys_clk);
        fault_ack_req = ack;
        standby_req = sby;
    endtask
endmodule // supervisor_model

// >>> tb/converter_status_word_reporter_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    mismatches++; $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module converter_status_word_reporter_tb;
    localparam logic [31:0] M = 32'h0180_07ff;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        critical_fault = 1'b0;
    logic [8:0]  flags = 9'h000;
    logic [1:0]  operating_mode_req;
    logic [2:0]  grid_config_req;
    logic        start_req;
    logic        stop_req;
    logic        standby_req;
    logic        fault_ack_req;
    wire  [31:0] converter_state_report;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [31:0] mask_q[$];
    logic [31:0] val_q[$];
    logic [31:0] w_m;
    logic [31:0] w_v;
    event        sample_ev;
    logic [1:0]  mode_tab[3] = '{2'h3, 2'h0, 2'h2};
    logic [2:0]  conf_tab[3] = '{3'h0, 3'h5, 3'h5};

    always #5 sys_clk = ~sys_clk;

    supervisor_model ctl (
        .sys_clk(sys_clk), .operating_mode_req(operating_mode_req),
        .grid_config_req(grid_config_req), .start_req(start_req),
        .stop_req(stop_req), .standby_req(standby_req),
        .fault_ack_req(fault_ack_req));

    // short counts keep the start-up walk to a few dozen cycles
    converter_status_word_reporter #(
        .INIT_CYC(16'd10), .PASSIVE_PRE_CYC(16'd20),
        .ACTIVE_PRE_CYC(16'd10), .INNER_STOP_CYC(16'd5)
    ) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .operating_mode_req(operating_mode_req),
        .grid_config_req(grid_config_req), .start_req(start_req),
        .stop_req(stop_req), .standby_req(standby_req),
        .critical_fault(critical_fault), .fault_ack_req(fault_ack_req),
        .max_current_limited(flags[0]), .max_voltage_limited(flags[1]),
        .grid_power_limited(flags[2]), .charge_current_limited(flags[3]),
        .discharge_current_limited(flags[4]),
        .input_current_limited(flags[5]), .heat_limited(flags[6]),
        .grid_present(flags[7]), .aggregating_master(flags[8]),
        .converter_state_report(converter_state_report));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] exp_flags(input logic [8:0] r);
        return {r[8], 2'b0, r[7:6], 1'b0, r[5], 3'b0, r[4:3], 1'b0, r[2:0],
            16'h0000};
    endfunction
    task automatic note(input logic [31:0] m, input logic [31:0] v);
        mask_q.push_back(m);
        val_q.push_back(v);
        -> sample_ev;
    endtask
    // bounded wait for a state pattern; a miss shows up as a mismatch
    task automatic st(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        while ((converter_state_report & m) !== v && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        note(m, v);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always begin
        @(sample_ev);
        while (val_q.size() > 0) begin
            w_m = mask_q.pop_front();
            w_v = val_q.pop_front();
            `CHK("status word", w_v, converter_state_report & w_m)
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h99d5));
        repeat (10) @(negedge sys_clk);
        note(32'hffff_ffff, 32'h0000_0000);
        sys_rst = 1'b0;
        st(32'hffff_ffff, 32'h0000_0111);
        for (int k = 0; k < 8; k++) begin
            flags = (k == 0) ? 9'h1ff : 9'($urandom());
            repeat (4) @(negedge sys_clk);
            note(32'hfe7f_0000, exp_flags(flags));
        end
        ctl.run(1'b1, 1'b0);
        repeat (30) @(negedge sys_clk);
        note(M, 32'h0000_0111);
        ctl.run(1'b0, 1'b0);
        for (int k = 0; k < 3; k++) begin
            ctl.set_mode(mode_tab[k], conf_tab[k]);
            repeat (5) @(negedge sys_clk);
            note(32'h0000_f800, {16'h0, conf_tab[k], mode_tab[k], 11'h0});
        end
        ctl.run(1'b1, 1'b0);
        st(M, 32'h0000_0121);
        st(M, 32'h0000_0131);
        st(M, 32'h0080_0241);
        st(M, 32'h0080_0252);
        st(M, 32'h0180_0353);
        ctl.set_mode(2'h3, 3'h0);
        repeat (6) @(negedge sys_clk);
        note(32'h0000_f8ff, 32'h0000_b053);
        ctl.run(1'b0, 1'b1);
        st(M, 32'h0180_0596);
        st(M, 32'h0000_06b7);
        st(M, 32'h0000_0111);
        ctl.run(1'b0, 1'b0);
        // second pass leaves the halt by a standby request instead of ack
        for (int k = 0; k < 2; k++) begin
            critical_fault = 1'b1;
            st(M, 32'h0000_04a4);
            repeat (20) @(negedge sys_clk);
            critical_fault = 1'b0;
            repeat (20) @(negedge sys_clk);
            note(M, 32'h0000_04a4);
            ctl.clear(k == 0, k == 1);
            if (k == 0) st(M, 32'h0000_07c8);
            st(M, 32'h0000_0111);
            ctl.clear(1'b0, 1'b0);
        end
        repeat (2) @(negedge sys_clk);
        tally_and_finish();
    end
endmodule // converter_status_word_reporter_tb

bind converter_status_word_reporter converter_status_word_reporter_monitor mon (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .operating_mode_req(operating_mode_req),
    .grid_config_req(grid_config_req), .start_req(start_req),
    .stop_req(stop_req), .standby_req(standby_req),
    .critical_fault(critical_fault), .fault_ack_req(fault_ack_req),
    .max_current_limited(max_current_limited),
    .max_voltage_limited(max_voltage_limited),
    .grid_power_limited(grid_power_limited),
    .charge_current_limited(charge_current_limited),
    .discharge_current_limited(discharge_current_limited),
    .input_current_limited(input_current_limited),
    .heat_limited(heat_limited), .grid_present(grid_present),
    .aggregating_master(aggregating_master),
    .converter_state_report(converter_state_report));
